// file: pkg/cmode_pkg.sv
package cmode_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_EVENT = 4'h8;
   localparam logic [3:0] REG_SEG = 4'hC;
   localparam int CTRL_EXT_BIT = 0;
   localparam int CTRL_PAGING_BIT = 1;
   localparam int FLAG_COMPAT_BIT = 17;
   localparam int FLAG_NESTED_BIT = 14;
   localparam int FLAG_IO_PRIVILEGE_LEVEL_LO = 12;
   localparam logic [1:0] PRIV_USER = 2'h3;
   localparam logic [1:0] PRIV_MONITOR = 2'h0;
   localparam logic [31:0] WRAP_LIMIT = 32'h0010FFEF;
   localparam logic [31:0] BAD_ADDR = 32'hDEADBEEF;

   // ****************************************************************
   // modes and events
   // ****************************************************************
   typedef enum logic [1:0]
   {
      CMODE_REAL = 2'h0,
      CMODE_PROT = 2'h1,
      CMODE_COMPAT = 2'h3
   } cmode_mode_t;

   typedef enum logic [3:0]
   {
      EV_NONE = 4'h0,
      EV_TASK_CALL = 4'h1,
      EV_TASK_BRANCH = 4'h2,
      EV_HANDLER_RET = 4'h3,
      EV_HW_IRQ = 4'h4,
      EV_EXCEPTION = 4'h5,
      EV_SOFT_INT = 4'h6,
      EV_HALT = 4'h7,
      EV_CLI = 4'h8,
      EV_STI = 4'h9,
      EV_FLAGS_PUSH = 4'hA,
      EV_FLAGS_POP = 4'hB,
      EV_PORT_IO = 4'hC,
      EV_SOFT_RESTART = 4'hD
   } cmode_event_t;

   typedef struct packed
   {
      logic [31:0] flag_image;
      logic record_32;
      logic [15:0] seg_image;
   } cmode_record_t;
endpackage

// file: verilog/cmode_ctrl.sv
`timescale 1ns/1ps
module cmode_ctrl
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [3:0] event_code,
   input wire logic event_valid,
   input wire cmode_pkg::cmode_record_t event_record,
   input wire logic [19:0] legacy_addr,
   input wire logic soft_restart_pin,
   output logic [31:0] linear_addr,
   output logic [1:0] current_privilege,
   output logic compat_mode_flag,
   output logic protection_fault,
   output logic soft_int_redirect,
   output logic translate_paged
);
   // ****************************************************************
   // state
   // ****************************************************************
   cmode_pkg::cmode_mode_t mode;
   logic [31:0] processor_flag_word;
   logic [31:0] seg_base;
   logic control_ext;
   logic control_paging;
   logic rst_meta;
   logic rst_sync;
   logic ack;
   logic [1:0] io_privilege_level;
   logic in_compat;
   logic [31:0] next_linear;
   logic next_fault;
   logic next_flag;
   logic [31:0] next_flags;

   assign in_compat = (mode == cmode_pkg::CMODE_COMPAT);
   assign io_privilege_level = processor_flag_word[cmode_pkg::FLAG_IO_PRIVILEGE_LEVEL_LO +: 2];

   // ****************************************************************
   // soft restart synchroniser
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end
      else
      begin
         rst_meta <= soft_restart_pin;
         rst_sync <= rst_meta;
      end
   end

   // ****************************************************************
   // incoming flag image
   // ****************************************************************
   always_comb
   begin
      next_flags = event_record.flag_image;
      if (!event_record.record_32)
      begin
         next_flags[31:16] = 16'h0000;
      end
      next_flag = next_flags[cmode_pkg::FLAG_COMPAT_BIT];
   end

   // ****************************************************************
   // mode control
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mode <= cmode_pkg::CMODE_REAL;
         processor_flag_word <= 32'h00000002;
         seg_base <= 32'h00000000;
      end
      else if (rst_sync || (event_valid && event_code == cmode_pkg::EV_SOFT_RESTART))
      begin
         mode <= cmode_pkg::CMODE_REAL;
         processor_flag_word <= 32'h00000002;
         seg_base <= 32'h00000000;
      end
      else if (event_valid)
      begin
         case (event_code)
            cmode_pkg::EV_TASK_CALL, cmode_pkg::EV_TASK_BRANCH:
            begin
               // flag, mode and segment base all load in the same cycle, base chosen by the record's compat bit
               processor_flag_word <= next_flags;
               mode <= next_flag ? cmode_pkg::CMODE_COMPAT : cmode_pkg::CMODE_PROT;
               seg_base <= next_flag ? {12'h000, event_record.seg_image, 4'h0}
                  : seg_base;
            end
            cmode_pkg::EV_HANDLER_RET:
            begin
               if (in_compat && io_privilege_level != cmode_pkg::PRIV_USER)
               begin
                  mode <= mode;
               end
               else if (in_compat)
               begin
                  // in-mode return forces compat flag to 1
                  processor_flag_word <= {processor_flag_word[31:18], 1'b1,
                     next_flags[16:0]};
               end
               else
               begin
                  // any non-compat return loads flags, mode and base from the record, as a task switch does
                  processor_flag_word <= next_flags;
                  mode <= next_flag ? cmode_pkg::CMODE_COMPAT : cmode_pkg::CMODE_PROT;
                  seg_base <= next_flag ? {12'h000, event_record.seg_image, 4'h0}
                     : seg_base;
               end
            end
            cmode_pkg::EV_HW_IRQ, cmode_pkg::EV_EXCEPTION, cmode_pkg::EV_HALT:
            begin
               if (mode != cmode_pkg::CMODE_REAL)
               begin
                  mode <= cmode_pkg::CMODE_PROT;
               end
            end
            cmode_pkg::EV_SOFT_INT, cmode_pkg::EV_CLI, cmode_pkg::EV_STI,
            cmode_pkg::EV_FLAGS_PUSH:
            begin
               if (in_compat && io_privilege_level != cmode_pkg::PRIV_USER)
               begin
                  mode <= cmode_pkg::CMODE_PROT;
               end
               else if (in_compat && event_code == cmode_pkg::EV_SOFT_INT && !control_ext)
               begin
                  mode <= cmode_pkg::CMODE_PROT;
               end
            end
            cmode_pkg::EV_FLAGS_POP:
            begin
               if (in_compat && io_privilege_level != cmode_pkg::PRIV_USER)
               begin
                  mode <= cmode_pkg::CMODE_PROT;
               end
               else
               begin
                  processor_flag_word <= {next_flags[31:18],
                     processor_flag_word[cmode_pkg::FLAG_COMPAT_BIT],
                     next_flags[16:0]};
               end
            end
            default:
            begin
               mode <= mode;
            end
         endcase
      end
   end

   // ****************************************************************
   // fault and routing outputs
   // ****************************************************************
   always_comb
   begin
      next_fault = 1'b0;
      if (event_valid && in_compat && !rst_sync)
      begin
         case (event_code)
            cmode_pkg::EV_HALT:
            begin
               next_fault = 1'b1;
            end
            cmode_pkg::EV_CLI, cmode_pkg::EV_STI, cmode_pkg::EV_FLAGS_PUSH,
            cmode_pkg::EV_FLAGS_POP, cmode_pkg::EV_SOFT_INT, cmode_pkg::EV_HANDLER_RET:
            begin
               next_fault = (io_privilege_level != cmode_pkg::PRIV_USER);
            end
            default:
            begin
               next_fault = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         protection_fault <= 1'b0;
         soft_int_redirect <= 1'b0;
      end
      else
      begin
         protection_fault <= next_fault;
         soft_int_redirect <= event_valid && in_compat && !rst_sync && control_ext
            && event_code == cmode_pkg::EV_SOFT_INT
            && io_privilege_level == cmode_pkg::PRIV_USER;
      end
   end

   // ****************************************************************
   // address formation and privilege
   // ****************************************************************
   always_comb
   begin
      next_linear = seg_base + {12'h000, legacy_addr};
      if (next_linear > cmode_pkg::WRAP_LIMIT)
      begin
         next_linear = cmode_pkg::WRAP_LIMIT;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         linear_addr <= 32'h00000000;
         current_privilege <= cmode_pkg::PRIV_MONITOR;
         compat_mode_flag <= 1'b0;
         translate_paged <= 1'b0;
      end
      else
      begin
         linear_addr <= next_linear;
         current_privilege <= in_compat ? cmode_pkg::PRIV_USER : cmode_pkg::PRIV_MONITOR;
         compat_mode_flag <= in_compat;
         translate_paged <= control_paging && mode != cmode_pkg::CMODE_REAL;
      end
   end

   // ****************************************************************
   // register slave
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         control_ext <= 1'b0;
         control_paging <= 1'b0;
         ack <= 1'b0;
         avs_readdata <= 32'h00000000;
      end
      else
      begin
         ack <= (avs_read || avs_write) && !ack;
         if (avs_write && !ack && avs_address == cmode_pkg::REG_CTRL)
         begin
            control_ext <= avs_writedata[cmode_pkg::CTRL_EXT_BIT];
            control_paging <= avs_writedata[cmode_pkg::CTRL_PAGING_BIT];
         end
         if (avs_read && !ack)
         begin
            if (avs_address == cmode_pkg::REG_CTRL)
            begin
               avs_readdata <= {30'h00000000, control_paging, control_ext};
            end
            else if (avs_address == cmode_pkg::REG_STATUS)
            begin
               avs_readdata <= {29'h00000000, in_compat, mode};
            end
            else if (avs_address == cmode_pkg::REG_EVENT)
            begin
               avs_readdata <= processor_flag_word;
            end
            else if (avs_address == cmode_pkg::REG_SEG)
            begin
               avs_readdata <= seg_base;
            end
            else
            begin
               avs_readdata <= cmode_pkg::BAD_ADDR;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         avs_waitrequest <= 1'b1;
      end
      else
      begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest && !ack);
      end
   end
endmodule

// file: test/cmode_properties.sv
`timescale 1ns/1ps
module cmode_properties
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] event_code,
   input wire logic event_valid,
   input wire cmode_pkg::cmode_record_t event_record,
   input wire logic soft_restart_pin,
   input wire logic [31:0] linear_addr,
   input wire logic [1:0] current_privilege,
   input wire logic compat_mode_flag,
   input wire logic protection_fault,
   input wire logic soft_int_redirect
);
   // ****************************************************************
   // mode checks
   // ****************************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic ev_sw;
   logic img_cm;
   assign ev_sw = event_valid && (event_code inside {cmode_pkg::EV_TASK_CALL,
      cmode_pkg::EV_TASK_BRANCH});
   assign img_cm = event_record.flag_image[cmode_pkg::FLAG_COMPAT_BIT];
   AST_USER_PRIV: assert property (compat_mode_flag |-> current_privilege == 2'h3)
      else $error("privilege not user in compat mode");
   AST_ADDR_LIMIT: assert property (compat_mode_flag |-> linear_addr <= 32'h0010FFEF)
      else $error("linear address above legacy range");
   AST_ENTRY: assert property
      (ev_sw && event_record.record_32 && img_cm |-> ##[1:3] compat_mode_flag)
      else $error("task switch did not enter compat mode");
   AST_REC16: assert property
      (ev_sw && !event_record.record_32 |-> ##[1:3] !compat_mode_flag)
      else $error("short record left compat mode set");
   AST_HW_EXIT: assert property
      (event_valid && (event_code inside {cmode_pkg::EV_HW_IRQ, cmode_pkg::EV_EXCEPTION})
      |-> ##[1:3] !compat_mode_flag)
      else $error("interrupt did not leave compat mode");
   AST_HALT: assert property
      (compat_mode_flag && event_valid && event_code == cmode_pkg::EV_HALT |=> protection_fault)
      else $error("halt raised no fault");
   AST_PORT: assert property
      (compat_mode_flag && event_valid && event_code == cmode_pkg::EV_PORT_IO
      |=> !protection_fault)
      else $error("port access faulted");
   AST_EXIT_CAUSE: assert property
      ($fell(compat_mode_flag) |-> $past(event_valid) || $past(event_valid, 2)
      || $past(soft_restart_pin, 4))
      else $error("compat mode left without cause");
   AST_REDIRECT: assert property
      (soft_int_redirect |-> compat_mode_flag ##1 compat_mode_flag)
      else $error("redirect left compat mode");
   AST_RESTART: assert property
      (soft_restart_pin [*3] |-> ##[0:3] (!compat_mode_flag && current_privilege == 2'h0))
      else $error("restart did not return to real mode");
   cover property ($rose(compat_mode_flag));
   cover property ($fell(compat_mode_flag));
   cover property (protection_fault);
   cover property (soft_int_redirect);
endmodule
bind cmode_ctrl cmode_properties i_props
(
   .clk(clk), .sys_rst(sys_rst), .event_code(event_code), .event_valid(event_valid),
   .event_record(event_record), .soft_restart_pin(soft_restart_pin),
   .linear_addr(linear_addr), .current_privilege(current_privilege),
   .compat_mode_flag(compat_mode_flag), .protection_fault(protection_fault),
   .soft_int_redirect(soft_int_redirect)
);

// file: test/cmode_monitor_model.sv
`timescale 1ns/1ps
module cmode_monitor_model
(
   output logic [3:0] event_code,
   output logic event_valid,
   output cmode_pkg::cmode_record_t event_record,
   input wire logic clk
);
   // ****************************************************************
   // event source
   // ****************************************************************
   // no page tables kept, wraparound alias not set up
   initial
   begin
      event_code = 4'h0;
      event_valid = 1'b0;
      event_record = '0;
   end
   task automatic send(input logic [3:0] c, input logic [31:0] f, input logic r32,
      input logic [15:0] s);
      @(posedge clk);
      event_code <= c;
      event_valid <= 1'b1;
      event_record <= {f, r32, s};
      @(posedge clk);
      event_valid <= 1'b0;
      event_code <= ~c;
      event_record <= ~{f, r32, s};
      repeat (3) @(posedge clk);
   endtask
endmodule

// file: test/test_compat_mode_entry_exit.sv
`timescale 1ns/1ps
module test_compat_mode_entry_exit;
   // ****************************************************************
   // bench
   // ****************************************************************
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [19:0] legacy_addr = 20'h0;
   logic soft_restart_pin = 1'b0;
   logic [31:0] avs_readdata, linear_addr, rd;
   logic avs_waitrequest, event_valid, compat_mode_flag, protection_fault;
   logic soft_int_redirect, translate_paged;
   logic [3:0] event_code;
   logic [1:0] current_privilege;
   cmode_pkg::cmode_record_t event_record;
   int n_mismatch = 0;
   int tests_run = 0;
   int n_fault = 0;
   int n_redir = 0;
   logic [3:0] ops [7] = '{cmode_pkg::EV_HALT, cmode_pkg::EV_CLI, cmode_pkg::EV_STI,
      cmode_pkg::EV_FLAGS_PUSH, cmode_pkg::EV_FLAGS_POP, cmode_pkg::EV_SOFT_INT,
      cmode_pkg::EV_HANDLER_RET};
   cmode_ctrl i_dut
   (
      .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .event_code(event_code), .event_valid(event_valid),
      .event_record(event_record), .legacy_addr(legacy_addr), .linear_addr(linear_addr),
      .soft_restart_pin(soft_restart_pin), .current_privilege(current_privilege),
      .compat_mode_flag(compat_mode_flag), .protection_fault(protection_fault),
      .soft_int_redirect(soft_int_redirect), .translate_paged(translate_paged)
   );
   cmode_monitor_model i_mon
   (
      .event_code(event_code), .event_valid(event_valid), .event_record(event_record),
      .clk(clk)
   );
   initial
   begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (protection_fault === 1'b1) n_fault++;
      if (soft_int_redirect === 1'b1) n_redir++;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic final_report;
      $display("mismatches %0d checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      final_report;
   end
   initial
   begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      bus(1'b1, cmode_pkg::REG_CTRL, 32'h00000003);
      bus(1'b0, cmode_pkg::REG_CTRL, 32'h0);
      check("ctrl", rd, 32'h00000003);
      bus(1'b0, 4'h1, 32'h0);
      check("unmapped", rd, 32'hDEADBEEF);
      legacy_addr <= 20'h00010;
      i_mon.send(cmode_pkg::EV_TASK_CALL, 32'h00023002, 1'b1, 16'h1234);
      check("compat", compat_mode_flag, 1);
      check("priv", current_privilege, 3);
      check("linear", linear_addr, 32'h00012350);
      check("paged", translate_paged, 1);
      legacy_addr <= 20'hFFFFF;
      i_mon.send(cmode_pkg::EV_TASK_BRANCH, 32'h00023002, 1'b1, 16'hFFFF);
      check("compat", compat_mode_flag, 1);
      check("linear", linear_addr, 32'h0010FFEF);
      bus(1'b0, cmode_pkg::REG_STATUS, 32'h0);
      check("status", rd, 32'h00000007);
      i_mon.send(cmode_pkg::EV_FLAGS_POP, 32'h00003002, 1'b1, 16'h0);
      check("compat", compat_mode_flag, 1);
      i_mon.send(cmode_pkg::EV_SOFT_INT, 32'h0, 1'b1, 16'h0);
      check("redirect", n_redir, 1);
      check("compat", compat_mode_flag, 1);
      i_mon.send(cmode_pkg::EV_HW_IRQ, 32'h0, 1'b1, 16'h0);
      check("compat", compat_mode_flag, 0);
      i_mon.send(cmode_pkg::EV_TASK_BRANCH, 32'h00020002, 1'b0, 16'h0100);
      check("compat", compat_mode_flag, 0);
      i_mon.send(cmode_pkg::EV_HANDLER_RET, 32'h00020002, 1'b1, 16'h0100);
      check("compat", compat_mode_flag, 1);
      bus(1'b0, cmode_pkg::REG_SEG, 32'h0);
      check("segbase", rd, 32'h00001000);
      i_mon.send(cmode_pkg::EV_PORT_IO, 32'h0, 1'b1, 16'h0);
      check("fault", n_fault, 0);
      for (int i = 0; i < 7; i++)
      begin
         i_mon.send(ops[i], 32'h00020002, 1'b1, 16'h0100);
         check("fault", n_fault, i + 1);
         if (ops[i] == cmode_pkg::EV_HANDLER_RET)
         begin
            check("compat", compat_mode_flag, 1);
            i_mon.send(cmode_pkg::EV_EXCEPTION, 32'h0, 1'b1, 16'h0);
         end
         check("compat", compat_mode_flag, 0);
         i_mon.send(cmode_pkg::EV_HANDLER_RET, 32'h00020002, 1'b1, 16'h0100);
      end
      bus(1'b1, cmode_pkg::REG_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      check("paged", translate_paged, 0);
      i_mon.send(cmode_pkg::EV_SOFT_RESTART, 32'h0, 1'b1, 16'h0);
      check("compat", compat_mode_flag, 0);
      check("priv", current_privilege, 0);
      i_mon.send(cmode_pkg::EV_HANDLER_RET, 32'h00020002, 1'b1, 16'h0100);
      check("compat", compat_mode_flag, 1);
      soft_restart_pin <= 1'b1;
      repeat (6) @(posedge clk);
      soft_restart_pin <= 1'b0;
      repeat (3) @(posedge clk);
      check("compat", compat_mode_flag, 0);
      check("priv", current_privilege, 0);
      bus(1'b0, cmode_pkg::REG_EVENT, 32'h0);
      check("flags", rd, 32'h00000002);
      final_report;
   end
endmodule
